/* src/stcu_defines.vh */
// constants for the scalar transfer and constant unit
`ifndef STCU_DEFINES_VH
`define STCU_DEFINES_VH
`define STCU_OP_071 7'o71
`define STCU_OP_072 7'o72
`define STCU_OP_073 7'o73
`define STCU_OP_074 7'o74
`define STCU_OP_075 7'o75
`define STCU_SUB_UNS 3'h0
`define STCU_SUB_SGN 3'h1
`define STCU_SUB_FLT 3'h2
`define STCU_SUB_C3 3'h3
`define STCU_SUB_C4 3'h4
`define STCU_SUB_C5 3'h5
`define STCU_SUB_C6 3'h6
`define STCU_SUB_C7 3'h7
`define STCU_K_RT 3'h0
`define STCU_K_SM 3'h2
`define STCU_K_ST 3'h3
`define STCU_K_STAT 3'h1
`define STCU_J_MASK 3'h0
`define STCU_J_PERF 3'h1
`define STCU_J_INC 3'h2
`define STCU_J_CLR 3'h3
// unnormalized float: biased exponent 0o40060 places a 24-bit value as integer
`define STCU_FLT_EXP 15'h4030
`define STCU_ONE_INT 64'h0000000000000001
`define STCU_ONE_UNF 64'h4030000000000001
// normalized constants: 0.75*2**48, 0.5, 1, 2, 4
`define STCU_C_FIX 64'h4030c00000000000
`define STCU_C_HALF 64'h4000800000000000
`define STCU_C_ONE 64'h4001800000000000
`define STCU_C_TWO 64'h4002800000000000
`define STCU_C_FOUR 64'h4003800000000000
`define STCU_ZERO64 64'h0000000000000000
`define STCU_ZERO32 32'h00000000
`define STCU_ZERO40 40'h0000000000
`define STCU_RT_STEP 64'h0000000000000001
`define STCU_NSAVE 64
`define STCU_NSHARED 8
`endif

/* src/stcu_unit.v */
// scalar transfer, constant entry, clock, semaphore and save datapath
//
// How it works
// - unsigned transfer zero-extends address value
// - signed transfer sign-extends address value
// - k zero gives integer one for unsigned and signed transfers
// - floating transfer gives unnormalized float
// - code 3 loads 0.75 times 2**48
// - codes 4..7 load 0.5,1,2,4
// - counter read copies all 64 bits
// - counter increments every clock it is not cleared
// - counter reset only in monitor mode
// - semaphore read left-justified, first bit sign
// - shared read copies selected shared register
// - shared write stores scalar into shared
// - semaphore load updates from scalar
// - save read copies save register to scalar
// - save write copies scalar to save
// - semaphore load takes top 32 bits
// - mask read copies all 64 mask bits
`timescale 1ns/1ns
`include "stcu_defines.vh"
module stcu_unit (
    input wire CLK_SYS,
    input wire RESET,
    input wire ISSUE,
    input wire [6:0] OPCODE,
    input wire [2:0] I_FIELD,
    input wire [2:0] J_FIELD,
    input wire [2:0] K_FIELD,
    input wire [23:0] ADDRESS_REG,
    input wire [63:0] SCALAR_IN,
    input wire [63:0] VECTOR_MASK_REG,
    input wire [63:0] STATUS_WORD_REG,
    input wire MONITOR_MODE,
    input wire RT_CLEAR,
    output reg S_WE,
    output reg [2:0] S_ADDR,
    output reg [63:0] S_DATA,
    output reg [63:0] REAL_TIME_OPERAND,
    output reg [31:0] SEMAPHORE_BITS
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [63:0] save_q [0:`STCU_NSAVE-1];
reg [63:0] shared_q [0:`STCU_NSHARED-1];
reg [63:0] res_d;
reg we_d;
reg sem_we;
reg save_we;
reg shared_we;
wire [5:0] jk = {J_FIELD, K_FIELD};
wire k_zero = (K_FIELD == 3'h0);
integer n;

// ----------------------------------------------------------------
// result select
// ----------------------------------------------------------------
always @* begin
    res_d = `STCU_ZERO64;
    we_d = 1'b0;
    sem_we = 1'b0;
    save_we = 1'b0;
    shared_we = 1'b0;
    if (ISSUE) begin
        case (OPCODE)
            `STCU_OP_071: begin
                we_d = 1'b1;
                case (J_FIELD)
                    `STCU_SUB_UNS: begin
                        if (k_zero)
                            res_d = `STCU_ONE_INT;
                        else
                            res_d = {`STCU_ZERO40, ADDRESS_REG};
                    end
                    `STCU_SUB_SGN: begin
                        if (k_zero)
                            res_d = `STCU_ONE_INT;
                        else
                            res_d = {{40{ADDRESS_REG[23]}}, ADDRESS_REG};
                    end
                    `STCU_SUB_FLT: begin
                        // exponent places the 24-bit value at the binary point
                        if (k_zero)
                            res_d = `STCU_ONE_UNF;
                        else
                            res_d = {1'b0, `STCU_FLT_EXP, 24'h000000,
                                ADDRESS_REG};
                    end
                    `STCU_SUB_C3: res_d = `STCU_C_FIX;
                    `STCU_SUB_C4: res_d = `STCU_C_HALF;
                    `STCU_SUB_C5: res_d = `STCU_C_ONE;
                    `STCU_SUB_C6: res_d = `STCU_C_TWO;
                    `STCU_SUB_C7: res_d = `STCU_C_FOUR;
                    default: we_d = 1'b0;
                endcase
                // constant entry is defined only with k zero
                if (J_FIELD >= `STCU_SUB_C3 && !k_zero)
                    we_d = 1'b0;
            end
            `STCU_OP_072: begin
                case (K_FIELD)
                    `STCU_K_RT: begin
                        we_d = 1'b1;
                        res_d = REAL_TIME_OPERAND;
                    end
                    `STCU_K_SM: begin
                        we_d = 1'b1;
                        res_d = {SEMAPHORE_BITS, `STCU_ZERO32};
                    end
                    `STCU_K_ST: begin
                        we_d = 1'b1;
                        res_d = shared_q[J_FIELD];
                    end
                    default: we_d = 1'b0;
                endcase
            end
            `STCU_OP_073: begin
                case ({J_FIELD, K_FIELD})
                    {`STCU_J_MASK, 3'h0}: begin
                        we_d = 1'b1;
                        res_d = VECTOR_MASK_REG;
                    end
                    {`STCU_J_MASK, `STCU_K_STAT}: begin
                        we_d = 1'b1;
                        res_d = STATUS_WORD_REG;
                    end
                    {`STCU_J_MASK, `STCU_K_SM}: sem_we = 1'b1;
                    // perf counter read/increment, maintenance clear codes: nothing written, no effect
                    {`STCU_J_PERF, `STCU_K_STAT},
                    {`STCU_J_INC, `STCU_K_STAT},
                    {`STCU_J_CLR, `STCU_K_STAT}: we_d = 1'b0;
                    default: begin
                        if (K_FIELD == `STCU_K_ST)
                            shared_we = 1'b1;
                    end
                endcase
            end
            `STCU_OP_074: begin
                we_d = 1'b1;
                res_d = save_q[jk];
            end
            `STCU_OP_075: save_we = 1'b1;
            default: we_d = 1'b0;
        endcase
    end
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
        S_WE <= 1'b0;
        S_ADDR <= 3'h0;
        S_DATA <= `STCU_ZERO64;
        REAL_TIME_OPERAND <= `STCU_ZERO64;
        SEMAPHORE_BITS <= `STCU_ZERO32;
        for (n = 0; n < `STCU_NSAVE; n = n + 1)
            save_q[n] <= `STCU_ZERO64;
        for (n = 0; n < `STCU_NSHARED; n = n + 1)
            shared_q[n] <= `STCU_ZERO64;
    end else begin
        S_WE <= we_d;
        S_ADDR <= I_FIELD;
        S_DATA <= res_d;
        // clear ignored outside monitor mode
        if (RT_CLEAR && MONITOR_MODE)
            REAL_TIME_OPERAND <= `STCU_ZERO64;
        else
            REAL_TIME_OPERAND <= REAL_TIME_OPERAND + `STCU_RT_STEP;
        if (sem_we)
            SEMAPHORE_BITS <= SCALAR_IN[63:32];
        if (save_we)
            save_q[jk] <= SCALAR_IN;
        if (shared_we)
            shared_q[J_FIELD] <= SCALAR_IN;
    end
end

endmodule

/* bench/stcu_unit_properties.sv */
// port assertions for the scalar transfer unit
`timescale 1ns/1ns
module stcu_unit_properties (
    input wire CLK_SYS, input wire RESET, input wire ISSUE,
    input wire MONITOR_MODE, input wire RT_CLEAR, input wire [6:0] OPCODE,
    input wire [2:0] J_FIELD, input wire [2:0] K_FIELD,
    input wire [23:0] ADDRESS_REG, input wire [63:0] SCALAR_IN,
    input wire [63:0] S_DATA, input wire [63:0] REAL_TIME_OPERAND,
    input wire [31:0] SEMAPHORE_BITS
);
default clocking @(posedge CLK_SYS); endclocking
default disable iff (RESET);
wire go1 = ISSUE && OPCODE == 7'h39;
wire clr = RT_CLEAR && MONITOR_MODE;
wire [31:0] hi = SCALAR_IN[63:32];
// k zero replaces the address operand by one
wire [63:0] uns = K_FIELD ? {40'h0, ADDRESS_REG} : 64'h1;
wire [63:0] cst = J_FIELD == 3'h3 ? 64'h4030c00000000000 :
    64'h4000800000000000 + ({61'h0, J_FIELD} - 64'h4 << 48);
uns_xfer_a: assert property (
    go1 && J_FIELD == 3'h0 |=> S_DATA == $past(uns)) else $error("uns");
sgn_xfer_a: assert property (
    go1 && J_FIELD == 3'h1 && K_FIELD != 3'h0
    |=> $signed(S_DATA) == $signed($past(ADDRESS_REG))) else $error("sgn");
flt_xfer_a: assert property (
    go1 && J_FIELD == 3'h2
    |=> S_DATA == ($past(uns) | 64'h4030 << 48)) else $error("flt");
const_load_a: assert property (
    go1 && J_FIELD > 3'h2 && K_FIELD == 3'h0
    |=> S_DATA == $past(cst)) else $error("const");
rt_step_a: assert property (
    !clr |=> REAL_TIME_OPERAND == $past(REAL_TIME_OPERAND) + 64'h1)
    else $error("rt step");
rt_clear_a: assert property (
    clr |=> REAL_TIME_OPERAND == 64'h0) else $error("rt clear");
sem_load_a: assert property (
    ISSUE && OPCODE == 7'h3b && J_FIELD == 3'h0 && K_FIELD == 3'h2
    |=> SEMAPHORE_BITS == $past(hi)) else $error("sem load");
sem_read_a: assert property (
    ISSUE && OPCODE == 7'h3a && J_FIELD == 3'h0 && K_FIELD == 3'h2
    |=> S_DATA == {$past(SEMAPHORE_BITS), 32'h0}) else $error("sem read");
cover property (go1 && K_FIELD == 3'h0);
cover property (go1 && J_FIELD == 3'h7);
cover property (clr);
endmodule
bind stcu_unit stcu_unit_properties stcu_unit_properties_i (.*);

/* bench/stcu_regs_model.sv */
// scalar and address register files facing the transfer unit
`timescale 1ns/1ns
module stcu_regs_model (
    input wire clk, input wire we, input wire [2:0] waddr,
    input wire [63:0] wdata, input wire [2:0] ri, input wire [2:0] rk,
    output wire [23:0] a_out, output wire [63:0] s_out
);
logic [63:0] s [8];
logic [23:0] a [8];
assign a_out = a[rk];
assign s_out = s[ri];
always @(posedge clk) if (we) s[waddr] <= wdata;
endmodule

/* bench/testbench.sv */
// self-checking bench for the scalar transfer unit
`timescale 1ns/1ns
module testbench;
reg clk_sys = 1'b0;
reg reset = 1'b1;
reg issue = 1'b0;
reg mon = 1'b0;
reg rtc = 1'b0;
reg [6:0] opc = 7'h0;
reg [2:0] fi = 3'h0;
reg [2:0] fj = 3'h0;
reg [2:0] fk = 3'h0;
reg [63:0] mask = 64'h0;
reg [63:0] r;
wire s_we;
wire [2:0] s_addr;
wire [23:0] ak;
wire [31:0] sem;
wire [63:0] s_data, rto, sin;
integer fail_count = 0;
integer num_checks = 0;
integer n;
stcu_unit stcu_unit_i (.CLK_SYS(clk_sys), .RESET(reset), .ISSUE(issue),
    .OPCODE(opc), .I_FIELD(fi), .J_FIELD(fj), .K_FIELD(fk),
    .ADDRESS_REG(ak), .SCALAR_IN(sin), .VECTOR_MASK_REG(mask),
    .STATUS_WORD_REG(64'h5a), .MONITOR_MODE(mon), .RT_CLEAR(rtc),
    .S_WE(s_we), .S_ADDR(s_addr), .S_DATA(s_data),
    .REAL_TIME_OPERAND(rto), .SEMAPHORE_BITS(sem));
stcu_regs_model m (.clk(clk_sys), .we(s_we), .waddr(s_addr),
    .wdata(s_data), .ri(fi), .rk(fk), .a_out(ak), .s_out(sin));
initial forever #20 clk_sys = ~clk_sys;
task chk(input [63:0] got, input [63:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
endtask
// result lands in the model one edge after the taking edge
task op(input [6:0] o, input [2:0] i, input [2:0] j, input [2:0] k);
    @(negedge clk_sys);
    {issue, opc, fi, fj, fk} = {1'b1, o, i, j, k};
    @(negedge clk_sys);
    issue = 1'b0;
    @(negedge clk_sys);
endtask
task t_xfer;
    m.a[5] = 24'h800123;
    op(7'h39, 3'h1, 3'h0, 3'h5);
    chk(m.s[1], 64'h800123);
    op(7'h39, 3'h1, 3'h1, 3'h5);
    chk(m.s[1], 64'hffffffffff800123);
    op(7'h39, 3'h1, 3'h2, 3'h5);
    chk(m.s[1], 64'h4030000000800123);
    op(7'h39, 3'h2, 3'h0, 3'h0);
    chk(m.s[2], 64'h1);
    op(7'h39, 3'h2, 3'h2, 3'h0);
    chk(m.s[2], 64'h4030000000000001);
    op(7'h39, 3'h2, 3'h1, 3'h0);
    chk(m.s[2], 64'h1);
    for (n = 3; n < 8; n = n + 1) begin
        op(7'h39, 3'h3, n[2:0], 3'h0);
        chk(m.s[3], n == 3 ? 64'h4030c00000000000 :
            64'h4000800000000000 + (64'(n - 4) << 48));
    end
endtask
task t_regs;
    m.s[3] = 64'h89abcdef01234567;
    op(7'h3b, 3'h3, 3'h0, 3'h2);
    chk({32'h0, sem}, 64'h89abcdef);
    op(7'h3a, 3'h4, 3'h0, 3'h2);
    chk(m.s[4], 64'h89abcdef00000000);
    op(7'h3b, 3'h3, 3'h5, 3'h3);
    op(7'h3a, 3'h6, 3'h5, 3'h3);
    chk(m.s[6], 64'h89abcdef01234567);
    op(7'h3d, 3'h4, 3'h7, 3'h7);
    op(7'h3c, 3'h7, 3'h7, 3'h7);
    chk(m.s[7], 64'h89abcdef00000000);
    mask = 64'hf00000000000000f;
    op(7'h3b, 3'h5, 3'h0, 3'h0);
    chk(m.s[5], 64'hf00000000000000f);
    for (n = 1; n < 4; n = n + 1) op(7'h3b, 3'h1, n[2:0], 3'h1);
    chk(m.s[1], 64'h4030000000800123);
    chk({32'h0, sem}, 64'h89abcdef);
endtask
task t_rt;
    r = rto;
    repeat (10) @(negedge clk_sys);
    chk(rto, r + 64'd10);
    rtc = 1'b1;
    @(negedge clk_sys);
    chk(rto, r + 64'd11);
    mon = 1'b1;
    @(negedge clk_sys);
    chk(rto, 64'h0);
    {rtc, mon} = 2'b00;
    // counter is 1 at the taking edge, two edges after the clear ends
    op(7'h3a, 3'h0, 3'h0, 3'h0);
    chk(m.s[0], 64'h1);
endtask
task print_verdict;
    if (fail_count == 0 && num_checks > 0) begin
        $display("*** PASS ***");
    end else begin
        $display("*** FAIL ***");
    end
    $finish;
endtask
initial begin
    for (n = 0; n < 8; n = n + 1) {m.s[n], m.a[n]} = 88'h0;
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    t_xfer;
    t_regs;
    t_rt;
    print_verdict;
end
endmodule
